// file: design/fsr_consts.svh
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH

// Opcodes
`define FSR_OP_SECREG_RD   8'h48
`define FSR_OP_SFDP_RD     8'h5a
`define FSR_OP_RST_ENABLE  8'h66
`define FSR_OP_RST_DO      8'h99

// Rising-edge counts within a frame
`define FSR_OPCODE_LAST    6'h07
`define FSR_ADDR_FIRST     6'h08
`define FSR_ADDR_LAST      6'h1f
`define FSR_DUMMY_LAST     6'h27
`define FSR_HEAD_DONE      6'h28

// Discoverable parameter header bytes
`define FSR_SIG_0          8'h53
`define FSR_SIG_1          8'h46
`define FSR_SIG_2          8'h44
`define FSR_SIG_3          8'h50
`define FSR_REV_MINOR      8'h00
`define FSR_REV_MAJOR      8'h01
`define FSR_NUM_HEADERS    8'h01
`define FSR_UNUSED_BYTE    8'hff
`define FSR_STD_TABLE_ID   8'h00
`define FSR_STD_TABLE_LEN  8'h09
`define FSR_STD_TABLE_PTR  8'h30
`define FSR_VND_TABLE_LEN  8'h03
`define FSR_VND_TABLE_PTR  8'h60
`define FSR_PTR_HIGH       8'h00

// Reset recovery time and clock
`define FSR_RECOVERY_NS    30000
`define FSR_CLK_PERIOD_NS  40
`define FSR_RECOVERY_CYC   ((`FSR_RECOVERY_NS + `FSR_CLK_PERIOD_NS - 1) / `FSR_CLK_PERIOD_NS)

`endif

// file: design/fsr_pkg.sv
package fsr_pkg;

   // Command being served in the current frame
   typedef enum logic [1:0] {
      MODE_IDLE,
      MODE_SECREG,
      MODE_SFDP,
      MODE_DROP
   } fsr_mode_t;

endpackage

// file: design/fsr_sync2.sv
module fsr_sync2 (
   // Destination clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Level in and synchronised level out
   input  wire logic d_i,
   output logic      q_o
);

   logic meta_ff;
   logic q_ff;

   // Two-flop synchroniser; first stage feeds only the second
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_ff <= 1'b0;
         q_ff    <= 1'b0;
      end else begin
         meta_ff <= d_i;
         q_ff    <= meta_ff;
      end
   end

   assign q_o = q_ff;

endmodule

// file: design/fsr_flash_slave.sv
// How it works
// - After 48H, 3 address bytes and one dummy byte, all sampled on rising clock.
// - Security register bytes shift out on the data output at falling clock edges.
// - Read starts at any byte; internal address advances by one per byte sent.
// - Low address byte wraps FFH to 00H, staying in the same register.
// - Output continues while clocked; raising chip select stops the output drive.
// - Accepted reset aborts work and clears all volatile state bits.
// - During reset recovery every command is refused.
// - 5AH returns bytes of a read-only parameter space, byte addressed.
// - Bytes 00H-06H: signature, revision 1.0, two parameter headers.
// - First header at 08H-0FH: ID 00H, rev 1.0, 9 words, pointer 30H.
// - Second header at 10H-17H: vendor ID, rev 1.0, 3 words, pointer 60H.
// - Bytes 07H, 0FH and 17H always read FFH.
`include "fsr_consts.svh"

module fsr_flash_slave
   import fsr_pkg::*;
#(
   parameter int          RECOVERY_CYC = `FSR_RECOVERY_CYC,
   parameter logic [7:0]  VENDOR_ID    = 8'h5e,  // Arbitrary value
   parameter int          VSTAT_W      = 8
) (
   // System clock and reset
   input  wire logic               clock_i,
   input  wire logic               sys_rst_i,
   // Serial link
   input  wire logic               sclk_i,
   input  wire logic               cs_n_i,
   input  wire logic               si_i,
   output logic                    so_o,
   output logic                    so_oe_o,
   // Security register contents load
   input  wire logic               secreg_wr_i,
   input  wire logic [9:0]         secreg_waddr_i,
   input  wire logic [7:0]         secreg_wdata_i,
   // Volatile state updates
   input  wire logic               latch_set_i,
   input  wire logic               latch_clr_i,
   input  wire logic               pause_set_i,
   input  wire logic               pause_clr_i,
   input  wire logic               param_wr_i,
   input  wire logic [7:0]         param_i,
   input  wire logic               cread_wr_i,
   input  wire logic [7:0]         cread_i,
   input  wire logic               wrap_wr_i,
   input  wire logic [2:0]         wrap_i,
   input  wire logic               vstat_wr_i,
   input  wire logic [VSTAT_W-1:0] vstat_i,
   // Volatile state and status
   output logic                    write_latch_flag_o,
   output logic                    paused_op_flag_o,
   output logic [7:0]              read_param_bits_o,
   output logic [7:0]              continuous_read_bits_o,
   output logic [2:0]              wrap_setting_bits_o,
   output logic [VSTAT_W-1:0]      vol_status_o,
   output logic                    abort_o,
   output logic                    busy_o
);

   localparam int CNT_W = 12;

   generate
      if (RECOVERY_CYC < 1 || RECOVERY_CYC >= (1 << CNT_W)) begin : g_bad_cyc
         $error("RECOVERY_CYC out of range");
      end
      if (VSTAT_W < 1) begin : g_bad_w
         $error("VSTAT_W must be positive");
      end
   endgenerate

   // Security register storage, four registers of 256 bytes
   logic [7:0] secreg_mem [0:1023];

   always_ff @(posedge clock_i) begin
      if (secreg_wr_i) begin
         secreg_mem[secreg_waddr_i] <= secreg_wdata_i;
      end
   end

   // Fixed parameter space; beyond the headers reads as all ones
   function automatic logic [7:0] sfdp_byte(input logic [23:0] a);
      logic [7:0] b;
      b = `FSR_UNUSED_BYTE;
      if (a[23:8] == 16'h0000) begin
         unique case (a[7:0])
            8'h00:   b = `FSR_SIG_0;
            8'h01:   b = `FSR_SIG_1;
            8'h02:   b = `FSR_SIG_2;
            8'h03:   b = `FSR_SIG_3;
            8'h04:   b = `FSR_REV_MINOR;
            8'h05:   b = `FSR_REV_MAJOR;
            8'h06:   b = `FSR_NUM_HEADERS;
            8'h08:   b = `FSR_STD_TABLE_ID;
            8'h09:   b = `FSR_REV_MINOR;
            8'h0a:   b = `FSR_REV_MAJOR;
            8'h0b:   b = `FSR_STD_TABLE_LEN;
            8'h0c:   b = `FSR_STD_TABLE_PTR;
            8'h0d:   b = `FSR_PTR_HIGH;
            8'h0e:   b = `FSR_PTR_HIGH;
            8'h10:   b = VENDOR_ID;
            8'h11:   b = `FSR_REV_MINOR;
            8'h12:   b = `FSR_REV_MAJOR;
            8'h13:   b = `FSR_VND_TABLE_LEN;
            8'h14:   b = `FSR_VND_TABLE_PTR;
            8'h15:   b = `FSR_PTR_HIGH;
            8'h16:   b = `FSR_PTR_HIGH;
            default: b = `FSR_UNUSED_BYTE;
         endcase
      end
      return b;
   endfunction

   // Crossing signals
   logic busy_ff;
   logic busy_lk;
   logic rst_tgl_ff;
   logic rst_tgl_sy;

   fsr_sync2 u_busy_sync (
      .clk_i (sclk_i),
      .rst_i (sys_rst_i),
      .d_i   (busy_ff),
      .q_o   (busy_lk)
   );

   fsr_sync2 u_rst_sync (
      .clk_i (clock_i),
      .rst_i (sys_rst_i),
      .d_i   (rst_tgl_ff),
      .q_o   (rst_tgl_sy)
   );

   // ---------------- Link domain, rising edge: frame decode ----------------
   logic      frame_rst;
   logic [5:0] cnt_ff,  nxt_cnt;
   logic [7:0] shift_ff, nxt_shift;
   logic [23:0] addr_ff, nxt_addr;
   fsr_mode_t mode_ff, nxt_mode;
   logic      data_ph_ff, nxt_data_ph;
   logic [7:0] opcode;

   assign frame_rst = sys_rst_i | cs_n_i;
   assign opcode    = {shift_ff[6:0], si_i};

   // Next frame state from the sampled input bit
   always_comb begin
      nxt_cnt     = cnt_ff;
      nxt_shift   = opcode;
      nxt_addr    = addr_ff;
      nxt_mode    = mode_ff;
      nxt_data_ph = data_ph_ff;
      if (cnt_ff != `FSR_HEAD_DONE) begin
         nxt_cnt = cnt_ff + 6'h01;
      end
      if (cnt_ff == `FSR_OPCODE_LAST) begin
         if (busy_lk) begin
            nxt_mode = MODE_DROP;
         end else if (opcode == `FSR_OP_SECREG_RD) begin
            nxt_mode = MODE_SECREG;
         end else if (opcode == `FSR_OP_SFDP_RD) begin
            nxt_mode = MODE_SFDP;
         end else begin
            nxt_mode = MODE_DROP;
         end
      end
      if (cnt_ff >= `FSR_ADDR_FIRST && cnt_ff <= `FSR_ADDR_LAST) begin
         nxt_addr = {addr_ff[22:0], si_i};
      end
      if (cnt_ff == `FSR_DUMMY_LAST && mode_ff != MODE_DROP) begin
         nxt_data_ph = 1'b1;
      end
   end

   // Frame registers, cleared whenever chip select is high
   always_ff @(posedge sclk_i or posedge frame_rst) begin
      if (frame_rst) begin
         cnt_ff     <= 6'h00;
         shift_ff   <= 8'h00;
         addr_ff    <= 24'h000000;
         mode_ff    <= MODE_IDLE;
         data_ph_ff <= 1'b0;
      end else begin
         cnt_ff     <= nxt_cnt;
         shift_ff   <= nxt_shift;
         addr_ff    <= nxt_addr;
         mode_ff    <= nxt_mode;
         data_ph_ff <= nxt_data_ph;
      end
   end

   // ---------------- Link domain: reset opcode pairing ----------------
   logic armed_ff, nxt_armed;
   logic nxt_rst_tgl;

   // Arm on a lone enable opcode; fire on the reset opcode that follows
   always_comb begin
      nxt_armed   = armed_ff;
      nxt_rst_tgl = rst_tgl_ff;
      if (cnt_ff == `FSR_OPCODE_LAST) begin
         nxt_armed = (opcode == `FSR_OP_RST_ENABLE) && !busy_lk;
         if (opcode == `FSR_OP_RST_DO && armed_ff && !busy_lk) begin
            nxt_rst_tgl = ~rst_tgl_ff;
         end
      end else if (cnt_ff == `FSR_ADDR_FIRST) begin
         nxt_armed = 1'b0;                      // Enable opcode not alone
      end
   end

   // Pairing state survives chip select
   always_ff @(posedge sclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         armed_ff   <= 1'b0;
         rst_tgl_ff <= 1'b0;
      end else begin
         armed_ff   <= nxt_armed;
         rst_tgl_ff <= nxt_rst_tgl;
      end
   end

   // ---------------- Link domain, falling edge: data out ----------------
   logic       on_ff,   nxt_on;
   logic       so_ff,   nxt_so;
   logic [7:0] tx_ff,   nxt_tx;
   logic [2:0] bit_ff,  nxt_bit;
   logic [7:0] ptr_ff,  nxt_ptr;
   logic [7:0] rd_lo;
   logic [7:0] rd_byte;

   // Byte at the current pointer
   always_comb begin
      rd_lo = on_ff ? ptr_ff : addr_ff[7:0];
      if (mode_ff == MODE_SECREG) begin
         rd_byte = secreg_mem[{addr_ff[9:8], rd_lo}];
      end else begin
         rd_byte = sfdp_byte({addr_ff[23:8], rd_lo});
      end
   end

   // Serialiser, most significant bit first
   always_comb begin
      nxt_on  = on_ff;
      nxt_so  = so_ff;
      nxt_tx  = tx_ff;
      nxt_bit = bit_ff;
      nxt_ptr = ptr_ff;
      if (data_ph_ff) begin
         nxt_on  = 1'b1;
         nxt_bit = bit_ff + 3'h1;
         if (!on_ff || bit_ff == 3'h0) begin
            nxt_so  = rd_byte[7];
            nxt_tx  = {rd_byte[6:0], 1'b0};
            nxt_ptr = rd_lo + 8'h01;
         end else begin
            nxt_so  = tx_ff[7];
            nxt_tx  = {tx_ff[6:0], 1'b0};
         end
      end
   end

   // Output registers; drive released as chip select rises
   always_ff @(negedge sclk_i or posedge frame_rst) begin
      if (frame_rst) begin
         on_ff  <= 1'b0;
         so_ff  <= 1'b0;
         tx_ff  <= 8'h00;
         bit_ff <= 3'h0;
         ptr_ff <= 8'h00;
      end else begin
         on_ff  <= nxt_on;
         so_ff  <= nxt_so;
         tx_ff  <= nxt_tx;
         bit_ff <= nxt_bit;
         ptr_ff <= nxt_ptr;
      end
   end

   assign so_o    = so_ff;
   assign so_oe_o = on_ff;

   // ---------------- System domain: reset and volatile state ----------------
   logic                 tgl_prev_ff;
   logic                 rst_seen;
   logic [CNT_W-1:0]     rec_ff,   nxt_rec;
   logic                 nxt_busy;
   logic                 abort_ff, nxt_abort;
   logic                 wl_ff,    nxt_wl;
   logic                 po_ff,    nxt_po;
   logic [7:0]           rp_ff,    nxt_rp;
   logic [7:0]           cr_ff,    nxt_cr;
   logic [2:0]           ws_ff,    nxt_ws;
   logic [VSTAT_W-1:0]   vs_ff,    nxt_vs;

   assign rst_seen = rst_rgl_edge(rst_tgl_sy, tgl_prev_ff);

   function automatic logic rst_rgl_edge(input logic a, input logic b);
      return a ^ b;
   endfunction

   // Reset acceptance, recovery countdown and state updates
   always_comb begin
      nxt_rec   = rec_ff;
      nxt_abort = 1'b0;
      nxt_wl    = wl_ff;
      nxt_po    = po_ff;
      nxt_rp    = rp_ff;
      nxt_cr    = cr_ff;
      nxt_ws    = ws_ff;
      nxt_vs    = vs_ff;
      if (rst_seen) begin
         nxt_rec   = CNT_W'(RECOVERY_CYC);
         nxt_abort = 1'b1;
         nxt_wl    = 1'b0;
         nxt_po    = 1'b0;
         nxt_rp    = 8'h00;
         nxt_cr    = 8'h00;
         nxt_ws    = 3'h0;
         nxt_vs    = '0;
      end else if (rec_ff != '0) begin
         nxt_rec = rec_ff - CNT_W'(1);
      end else begin
         if (latch_set_i) begin
            nxt_wl = 1'b1;
         end else if (latch_clr_i) begin
            nxt_wl = 1'b0;
         end
         if (pause_set_i) begin
            nxt_po = 1'b1;
         end else if (pause_clr_i) begin
            nxt_po = 1'b0;
         end
         if (param_wr_i) begin
            nxt_rp = param_i;
         end
         if (cread_wr_i) begin
            nxt_cr = cread_i;
         end
         if (wrap_wr_i) begin
            nxt_ws = wrap_i;
         end
         if (vstat_wr_i) begin
            nxt_vs = vstat_i;
         end
      end
      nxt_busy = (nxt_rec != '0);
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tgl_prev_ff <= 1'b0;
         rec_ff      <= '0;
         busy_ff     <= 1'b0;
         abort_ff    <= 1'b0;
         wl_ff       <= 1'b0;
         po_ff       <= 1'b0;
         rp_ff       <= 8'h00;
         cr_ff       <= 8'h00;
         ws_ff       <= 3'h0;
         vs_ff       <= '0;
      end else begin
         tgl_prev_ff <= rst_tgl_sy;
         rec_ff      <= nxt_rec;
         busy_ff     <= nxt_busy;
         abort_ff    <= nxt_abort;
         wl_ff       <= nxt_wl;
         po_ff       <= nxt_po;
         rp_ff       <= nxt_rp;
         cr_ff       <= nxt_cr;
         ws_ff       <= nxt_ws;
         vs_ff       <= nxt_vs;
      end
   end

   // Volatile state outputs
   assign write_latch_flag_o     = wl_ff;
   assign paused_op_flag_o       = po_ff;
   assign read_param_bits_o      = rp_ff;
   assign continuous_read_bits_o = cr_ff;
   assign wrap_setting_bits_o    = ws_ff;
   assign vol_status_o           = vs_ff;
   assign abort_o                = abort_ff;
   assign busy_o                 = busy_ff;

endmodule

// file: tb/fsr_host_model.sv
module fsr_host_model (
   // Link lines driven by the host
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      si_o,
   // Device answer
   input  wire logic so_i,
   input  wire logic so_oe_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] rd_q [$];
   int         oe_n;
   // Idle link, clock parked low between frames
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      si_o   = 1'b0;
   end
   // One frame: header bits MSB first, then nrd bytes captured on rise
   task automatic frame(input logic [39:0] hdr, input int nbits, input int nrd);
      logic [7:0] b;
      rd_q.delete();
      oe_n = 0;
      // Odd start offset keeps link edges off the system clock grid
      #5.3 cs_n_o = 1'b0;
      for (int i = 0; i < nbits + 8 * nrd; i++) begin
         si_o = (i < nbits) ? hdr[39-i] : ~si_o;
         #3 sclk_o = 1'b1;
         if (i >= nbits) begin
            b = {b[6:0], so_i};
            if (so_oe_i === 1'b1) oe_n++;
            if ((i - nbits) % 8 == 7) rd_q.push_back(b);
         end
         #3 sclk_o = 1'b0;
      end
      #5 cs_n_o = 1'b1;
   endtask
endmodule

// file: tb/fsr_flash_slave_sva.sv
module fsr_flash_slave_chk
   import fsr_pkg::*;
#(
   parameter int RECOVERY_CYC = 8,
   parameter int VSTAT_W      = 8
) (
   // Clock and reset
   input wire logic               clock_i,
   input wire logic               sys_rst_i,
   // Watched ports
   input wire logic               cs_n_i,
   input wire logic               so_oe_o,
   input wire logic               param_wr_i,
   input wire logic [7:0]         param_i,
   input wire logic               write_latch_flag_o,
   input wire logic               paused_op_flag_o,
   input wire logic [7:0]         read_param_bits_o,
   input wire logic [7:0]         continuous_read_bits_o,
   input wire logic [2:0]         wrap_setting_bits_o,
   input wire logic [VSTAT_W-1:0] vol_status_o,
   input wire logic               abort_o,
   input wire logic               busy_o
);
   int busy_cnt_ff;
   int nxt_busy_cnt;
   // Length of the current busy stretch
   always_comb nxt_busy_cnt = busy_o ? busy_cnt_ff + 1 : 0;
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) busy_cnt_ff <= 0;
      else busy_cnt_ff <= nxt_busy_cnt;
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   a_abort_single: assert property (abort_o |=> !abort_o)
      else $error("abort pulse too long");
   a_abort_clears: assert property (abort_o |-> !write_latch_flag_o && !paused_op_flag_o
      && read_param_bits_o == 8'h00 && continuous_read_bits_o == 8'h00
      && wrap_setting_bits_o == 3'h0 && vol_status_o == '0)
      else $error("state kept after abort");
   a_abort_busy: assert property (abort_o |-> busy_o && !$past(busy_o))
      else $error("abort without fresh busy");
   a_busy_rise: assert property ($rose(busy_o) |-> abort_o)
      else $error("busy without abort");
   a_busy_length: assert property ($fell(busy_o) |-> busy_cnt_ff == RECOVERY_CYC)
      else $error("recovery length wrong");
   a_busy_cap: assert property (busy_cnt_ff <= RECOVERY_CYC)
      else $error("recovery too long");
   a_busy_frozen: assert property (busy_o |=> $stable(read_param_bits_o)
      && $stable(write_latch_flag_o) && $stable(vol_status_o))
      else $error("load taken while busy");
   a_param_take: assert property (param_wr_i && !busy_o
      |=> abort_o || read_param_bits_o == $past(param_i))
      else $error("parameter load lost");
   a_cs_stops_out: assert property (cs_n_i |-> !so_oe_o)
      else $error("output driven while deselected");
endmodule

// file: tb/testbench.sv
bind fsr_flash_slave fsr_flash_slave_chk #(.RECOVERY_CYC(RECOVERY_CYC), .VSTAT_W(VSTAT_W))
   fsr_flash_slave_chk_i (.clock_i, .sys_rst_i, .cs_n_i, .so_oe_o, .param_wr_i, .param_i,
   .write_latch_flag_o, .paused_op_flag_o, .read_param_bits_o, .continuous_read_bits_o,
   .wrap_setting_bits_o, .vol_status_o, .abort_o, .busy_o);

module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int         RCYC   = 40;
   localparam logic [7:0] VID    = 8'ha7;  // Arbitrary value
   localparam logic [31:0] LOADED = {3'h0, 2'h3, 8'h5c, 8'ha3, 3'h5, 8'h96};
   logic       clock_i   = 1'b0;
   logic       sys_rst_i = 1'b1;
   logic       sclk, cs_n, si, so, so_oe, abort, busy, wl, po;
   logic       sw = 1'b0, ls = 1'b0, lc = 1'b0, ps = 1'b0, pc = 1'b0;
   logic       pw = 1'b0, cw = 1'b0, ww = 1'b0, vw = 1'b0;
   logic [9:0] sa = 10'h000;
   logic [7:0] sd = 8'h00, pv = 8'h00, cv = 8'h00, vv = 8'h00, rp, cr, vs;
   logic [2:0] wv = 3'h0, wrp;
   logic [7:0] sfdp [26];
   int         mismatches = 0, checks_done = 0, aborts = 0;
   // System clock and abort counter
   always #20 clock_i = ~clock_i;
   always @(posedge clock_i) if (abort === 1'b1) aborts <= aborts + 1;
   fsr_flash_slave #(.RECOVERY_CYC(RCYC), .VENDOR_ID(VID), .VSTAT_W(8)) fsr_flash_slave_i (
      .clock_i(clock_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
      .so_o(so), .so_oe_o(so_oe), .secreg_wr_i(sw), .secreg_waddr_i(sa), .secreg_wdata_i(sd),
      .latch_set_i(ls), .latch_clr_i(lc), .pause_set_i(ps), .pause_clr_i(pc),
      .param_wr_i(pw), .param_i(pv), .cread_wr_i(cw), .cread_i(cv), .wrap_wr_i(ww),
      .wrap_i(wv), .vstat_wr_i(vw), .vstat_i(vv), .write_latch_flag_o(wl),
      .paused_op_flag_o(po), .read_param_bits_o(rp), .continuous_read_bits_o(cr),
      .wrap_setting_bits_o(wrp), .vol_status_o(vs), .abort_o(abort), .busy_o(busy));
   fsr_host_model fsr_host_model_i (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so),
      .so_oe_i(so_oe));
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   function automatic logic [7:0] pat(input logic [9:0] a);
      return a[7:0] ^ {a[9:8], 6'h2b};
   endfunction
   function automatic logic [31:0] st();
      return {3'h0, wl, po, rp, cr, wrp, vs};
   endfunction
   // Lone opcode frame
   task automatic op(input logic [7:0] c);
      fsr_host_model_i.frame({c, 32'h0}, 8, 0);
   endtask
   // Main sequence
   initial begin
      sfdp = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hff, 8'h00, 8'h00, 8'h01,
               8'h09, 8'h30, 8'h00, 8'h00, 8'hff, VID, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00,
               8'h00, 8'hff, 8'hff, 8'hff};
      repeat (16) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 1024; i++) begin
         @(posedge clock_i);
         sw <= 1'b1;
         sa <= i[9:0];
         sd <= pat(i[9:0]);
      end
      @(posedge clock_i);
      sw <= 1'b0;
      for (int r = 0; r < 4; r++) begin
         fsr_host_model_i.frame({8'h48, 14'h0, r[1:0], 8'hfe, 8'h00}, 40, 3);
         chk(fsr_host_model_i.oe_n, 24);
         for (int k = 0; k < 3; k++) begin
            chk(fsr_host_model_i.rd_q[k], pat({r[1:0], 8'hfe + k[7:0]}));
         end
      end
      fsr_host_model_i.frame({8'h5a, 32'h0}, 40, 26);
      for (int k = 0; k < 26; k++) begin
         chk(fsr_host_model_i.rd_q[k], sfdp[k]);
      end
      @(posedge clock_i);
      {ls, lc, ps, pc, pw, cw, ww, vw} <= 8'hff;
      {pv, cv, wv, vv} <= {8'h5c, 8'ha3, 3'h5, 8'h96};
      @(posedge clock_i);
      {ls, lc, ps, pc, pw, cw, ww, vw} <= 8'h00;
      @(posedge clock_i);
      chk(st(), LOADED);
      chk(busy, 0);
      op(8'h99);
      op(8'h66);
      fsr_host_model_i.frame({8'h5a, 32'h0}, 40, 1);
      op(8'h99);
      repeat (8) @(posedge clock_i);
      chk(aborts, 0);
      chk(st(), LOADED);
      op(8'h66);
      op(8'h99);
      for (int i = 0; i < 20 && aborts == 0; i++) @(posedge clock_i);
      chk(aborts, 1);
      chk(st(), 0);
      fsr_host_model_i.frame({8'h5a, 32'h0}, 40, 1);
      chk(fsr_host_model_i.oe_n, 0);
      @(posedge clock_i);
      {ls, pw} <= 2'h3;
      pv <= 8'h11;
      @(posedge clock_i);
      {ls, pw} <= 2'h0;
      @(posedge clock_i);
      chk(busy, 1);
      chk(st(), 0);
      for (int i = 0; i < 100 && busy !== 1'b0; i++) @(posedge clock_i);
      chk(busy, 0);
      // Flags set, then cleared alone, once recovery is over
      @(posedge clock_i);
      {ls, ps} <= 2'h3;
      @(posedge clock_i);
      {ls, ps, lc, pc} <= 4'h3;
      @(negedge clock_i);
      chk({wl, po}, 2'h3);
      @(posedge clock_i);
      {lc, pc} <= 2'h0;
      @(negedge clock_i);
      chk({wl, po}, 2'h0);
      fsr_host_model_i.frame({8'h5a, 24'h000010, 8'h00}, 40, 8);
      for (int k = 0; k < 8; k++) chk(fsr_host_model_i.rd_q[k], sfdp[16+k]);
      close_out();
   end
   // Watchdog
   initial begin
      #2000000;
      mismatches++;
      close_out();
   end
endmodule
